// ==== hw/cce_exec.sv ====
// Overview of operation
// - Byte compare subtracts zero-extended immediate; flags only.
// - Accumulator source sets overflow, sign, zero and carry flags.
// - Index register source sets pointer carry and pointer zero instead.
// - Byte compare takes one cycle, ignores repeat, advances PC by one.
// - Index form gathers scattered immediate bits; register from 4..2.
// - String compare subtracts second string from first; only flags change.
// - Data-memory second operand also updates the tag flag.
// - Correlation step multiplies two signed memory words into 48-bit sum.
// - Result lands in three consecutive accumulators from the selected one.
// - Three cycles per tap; repeat count plus two taps, so three times (count plus two) cycles.
// - First coefficient to multiplier operand; samples even, taps odd.
// - Even pointer adds step register on tag, else post-increments when pinc is set.
// - Interrupts stay queued until the correlation sequence completes.
// - Correlation opcode decoded as 1110100, An, 110, Rx, 11.
`timescale 1ns/1ps
module cce_exec (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [11:0] wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        irq_request_in,
    input  wire logic        irq_ack_in,
    output logic             irq_service_out,
    output logic             busy_out
);
    cce_pkg::cce_state_e state, next_state;
    logic [16:0] op, next_op;
    logic [7:0]  flags, next_flags;
    logic [7:0]  repeat_prefix, next_rpt;
    logic        pinc, next_pinc;
    logic [7:0]  stra, next_stra;
    logic [7:0]  strb, next_strb;
    logic [7:0]  strn, next_strn;
    logic [15:0] pc, next_pc;
    logic [15:0] mr, next_mr;
    logic [15:0] xreg, next_xreg;
    logic [15:0] idx [cce_pkg::NUM_REGS];
    logic [15:0] next_idx [cce_pkg::NUM_REGS];
    logic [15:0] acc [cce_pkg::NUM_REGS];
    logic [15:0] next_acc [cce_pkg::NUM_REGS];
    logic [8:0]  cnt, next_cnt;
    logic        borrow, next_borrow;
    logic        zacc, next_zacc;
    logic        mem_pend, next_mem_pend;
    logic        irq_pend, next_irq_pend;
    logic        next_irq_srv;
    logic        next_busy;
    logic        next_ack;
    logic [31:0] next_rdata;

    logic [7:0]  mem_addr;
    logic        mem_we;
    logic [16:0] mem_wdata;
    logic [16:0] mem_rdata;
    logic        mac_clear;
    logic        mac_en;
    logic [47:0] mac_acc;
    logic [47:0] mac_sum;

    // Returns {overflow, borrow, difference}
    function automatic logic [17:0] sub_word(input logic [15:0] a,
                                             input logic [15:0] b,
                                             input logic        bin);
        logic [16:0] d;
        logic        v;
        d = {1'b0, a} - {1'b0, b} - {16'h0000, bin};
        v = (a[15] ^ b[15]) & (a[15] ^ d[15]);
        return {v, d};
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  sel);
        return {sel[1] ? data[15:8] : old[15:8],
                sel[0] ? data[7:0] : old[7:0]};
    endfunction

    function automatic logic [2:0] wrap(input logic [2:0] base,
                                        input logic [8:0] ofs);
        return base + ofs[2:0];
    endfunction

    cce_word_mem #(
        .DATA_W (cce_pkg::MEM_DATA_W),
        .ADDR_W (cce_pkg::MEM_ADDR_W)
    ) u_mem (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .we_in     (mem_we),
        .addr_in   (mem_addr),
        .wdata_in  (mem_wdata),
        .rdata_out (mem_rdata)
    );

    cce_mac #(
        .OP_W  (16),
        .ACC_W (48)
    ) u_mac (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .clear_in (mac_clear),
        .en_in    (mac_en),
        .a_in     (xreg),
        .b_in     (mem_rdata[15:0]),
        .acc_out  (mac_acc),
        .sum_out  (mac_sum)
    );

    always_comb
    begin
        logic        req;
        logic        is_mem;
        logic        go;
        logic [16:0] cop;
        logic [17:0] r;
        logic [7:0]  imm;
        logic [2:0]  ra;
        logic [2:0]  rb;
        logic [2:0]  ev;
        logic [15:0] sa;
        logic [15:0] sb;
        logic        last;
        req = 1'b0; is_mem = 1'b0; go = 1'b0; cop = '0; r = '0;
        imm = '0; ra = '0; rb = '0; ev = '0; sa = '0; sb = '0; last = 1'b0;
        next_state = state; next_op = op; next_flags = flags;
        next_rpt = repeat_prefix; next_pinc = pinc; next_stra = stra;
        next_strb = strb; next_strn = strn; next_pc = pc; next_mr = mr;
        next_xreg = xreg; next_idx = idx; next_acc = acc; next_cnt = cnt;
        next_borrow = borrow; next_zacc = zacc; next_mem_pend = 1'b0;
        next_ack = 1'b0; next_rdata = '0;
        mem_addr = '0; mem_we = 1'b0; mem_wdata = '0;
        mac_clear = 1'b0; mac_en = 1'b0;

        // Bus slave; while busy only register reads are served
        req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
        is_mem = wb_adr_in[11:10] == cce_pkg::OFS_MEM[11:10];
        go = req & (state == cce_pkg::ST_IDLE | (~wb_we_in & ~is_mem));
        if (go && is_mem)
        begin
            mem_addr = wb_adr_in[9:2];
            if (wb_we_in)
            begin
                mem_we = 1'b1;
                mem_wdata = {wb_sel_in[2] ? wb_dat_in[16] : 1'b0,
                             merge16(16'h0000, wb_dat_in, wb_sel_in)};
                next_ack = 1'b1;
            end
            else if (mem_pend)
            begin
                next_ack = 1'b1;
                next_rdata = {15'h0000, mem_rdata};
            end
            else
            begin
                next_mem_pend = 1'b1;
            end
        end
        else if (go)
        begin
            next_ack = 1'b1;
            if (wb_adr_in[11:6] == cce_pkg::OFS_IDX[11:6])
            begin
                next_rdata = {16'h0000, idx[wb_adr_in[4:2]]};
                if (wb_we_in && !wb_adr_in[5])
                    next_idx[wb_adr_in[4:2]] =
                        merge16(idx[wb_adr_in[4:2]], wb_dat_in, wb_sel_in);
                if (wb_adr_in[5])
                    next_rdata = '0;
            end
            else if (wb_adr_in[11:6] == cce_pkg::OFS_ACC[11:6])
            begin
                next_rdata = {16'h0000, acc[wb_adr_in[4:2]]};
                if (wb_we_in && !wb_adr_in[5])
                    next_acc[wb_adr_in[4:2]] =
                        merge16(acc[wb_adr_in[4:2]], wb_dat_in, wb_sel_in);
                if (wb_adr_in[5])
                    next_rdata = '0;
            end
            else
            begin
                unique case (wb_adr_in)
                    cce_pkg::OFS_CMD:
                        next_rdata = {14'h0000, state != cce_pkg::ST_IDLE, op};
                    cce_pkg::OFS_STAT:
                    begin
                        next_rdata = {24'h000000, flags};
                        if (wb_we_in && wb_sel_in[0])
                            next_flags = wb_dat_in[7:0];
                    end
                    cce_pkg::OFS_CFG:
                    begin
                        next_rdata = {23'h000000, pinc, repeat_prefix};
                        if (wb_we_in && wb_sel_in[0])
                            next_rpt = wb_dat_in[7:0];
                        if (wb_we_in && wb_sel_in[1])
                            next_pinc = wb_dat_in[cce_pkg::CFG_PINC];
                    end
                    cce_pkg::OFS_STRA:
                    begin
                        next_rdata = {24'h000000, stra};
                        if (wb_we_in && wb_sel_in[0])
                            next_stra = wb_dat_in[7:0];
                    end
                    cce_pkg::OFS_STRB:
                    begin
                        next_rdata = {24'h000000, strb};
                        if (wb_we_in && wb_sel_in[0])
                            next_strb = wb_dat_in[7:0];
                    end
                    cce_pkg::OFS_STRN:
                    begin
                        next_rdata = {24'h000000, strn};
                        if (wb_we_in && wb_sel_in[0])
                            next_strn = wb_dat_in[7:0];
                    end
                    cce_pkg::OFS_PC:
                    begin
                        next_rdata = {16'h0000, pc};
                        if (wb_we_in)
                            next_pc = merge16(pc, wb_dat_in, wb_sel_in);
                    end
                    cce_pkg::OFS_MR:
                        next_rdata = {16'h0000, mr};
                    default:
                        next_rdata = '0;
                endcase
            end
        end

        cop = wb_dat_in[16:0];
        unique case (state)
            cce_pkg::ST_IDLE:
            begin
                if (go && wb_we_in && !is_mem && wb_adr_in == cce_pkg::OFS_CMD
                    && wb_sel_in[2:0] == 3'h7)
                begin
                    next_op = cop;
                    next_cnt = '0;
                    next_borrow = 1'b0;
                    next_zacc = 1'b1;
                    if (cop[16:10] == cce_pkg::OP_BYTE_ACC)
                    begin
                        r = sub_word(acc[{1'b0, cop[9:8]}],
                                     {8'h00, cop[7:0]}, 1'b0);
                        next_flags[cce_pkg::FLG_OVF] = r[17];
                        next_flags[cce_pkg::FLG_SGN] = r[15];
                        next_flags[cce_pkg::FLG_ZER] = r[15:0] == 16'h0000;
                        next_flags[cce_pkg::FLG_CAR] = r[16];
                        next_pc = pc + 16'h0001;
                    end
                    else if (cop[16:11] == cce_pkg::OP_BYTE_IDX)
                    begin
                        imm = {cop[7:5], cop[10:8], cop[1:0]};
                        r = sub_word(idx[cop[4:2]], {8'h00, imm}, 1'b0);
                        next_flags[cce_pkg::FLG_PCAR] = r[16];
                        next_flags[cce_pkg::FLG_PZER] = r[15:0] == 16'h0000;
                        next_pc = pc + 16'h0001;
                    end
                    else if (cop[16:10] == cce_pkg::OP_STR_MEM
                             || (cop[16:10] == cce_pkg::OP_STR_REG && !cop[0]
                                 && (cop[7:2] == cce_pkg::OP_STR_PMA
                                     || cop[7:2] == cce_pkg::OP_STR_ACC)))
                    begin
                        next_state = cce_pkg::ST_STR_RD;
                        next_pc = (cop[16] && cop[7:2] == cce_pkg::OP_STR_PMA)
                                  ? pc + 16'h0002 : pc + 16'h0001;
                    end
                    else if (cop[16:10] == cce_pkg::OP_COR
                             && cop[7:5] == cce_pkg::OP_COR_MID
                             && cop[1:0] == cce_pkg::OP_COR_LOW)
                    begin
                        mac_clear = 1'b1;
                        next_state = cce_pkg::ST_COR_X;
                        next_pc = pc + 16'h0001;
                    end
                    else
                    begin
                        next_flags[cce_pkg::FLG_BAD] = 1'b1;
                    end
                end
            end
            cce_pkg::ST_STR_RD:
            begin
                mem_addr = strb + cnt[7:0];
                next_state = cce_pkg::ST_STR_CMP;
            end
            cce_pkg::ST_STR_CMP:
            begin
                ra = {1'b0, op[9:8]};
                rb = ra + cce_pkg::ALT_OFS;
                if (op[16] && op[1])
                begin
                    ra = rb;
                    rb = {1'b0, op[9:8]};
                end
                sa = acc[wrap(ra, cnt)];
                sb = (op[16] && op[7:2] == cce_pkg::OP_STR_ACC)
                     ? acc[wrap(rb, cnt)] : mem_rdata[15:0];
                r = sub_word(sa, sb, borrow);
                next_borrow = r[16];
                next_zacc = zacc & (r[15:0] == 16'h0000);
                if (cnt[7:0] == strn)
                begin
                    next_flags[cce_pkg::FLG_OVF] = r[17];
                    next_flags[cce_pkg::FLG_SGN] = r[15];
                    next_flags[cce_pkg::FLG_ZER] = next_zacc;
                    next_flags[cce_pkg::FLG_CAR] = r[16];
                    if (!op[16])
                        next_flags[cce_pkg::FLG_TAG] =
                            mem_rdata[cce_pkg::MEM_TAG];
                    next_state = cce_pkg::ST_IDLE;
                end
                else
                begin
                    next_cnt = cnt + 9'h001;
                    next_state = cce_pkg::ST_STR_RD;
                end
            end
            cce_pkg::ST_COR_X:
            begin
                ev = {op[4:3], 1'b0};
                mem_addr = idx[ev][7:0];
                next_state = cce_pkg::ST_COR_H;
            end
            cce_pkg::ST_COR_H:
            begin
                ev = {op[4:3], 1'b0};
                next_xreg = mem_rdata[15:0];
                mem_addr = idx[ev | 3'h1][7:0];
                next_state = cce_pkg::ST_COR_MAC;
            end
            cce_pkg::ST_COR_MAC:
            begin
                ev = {op[4:3], 1'b0};
                mac_en = 1'b1;
                if (cnt == 9'h000)
                    next_mr = mem_rdata[15:0];
                next_idx[ev | 3'h1] = idx[ev | 3'h1] + 16'h0001;
                if (flags[cce_pkg::FLG_TAG])
                    next_idx[ev] = idx[ev] + idx[cce_pkg::STEP_REG];
                else if (pinc)
                    next_idx[ev] = idx[ev] + 16'h0001;
                last = cnt == {1'b0, repeat_prefix} + 9'h001;
                if (last)
                begin
                    ra = {1'b0, op[9:8]};
                    next_acc[ra] = mac_sum[15:0];
                    next_acc[ra + 3'h1] = mac_sum[31:16];
                    next_acc[ra + 3'h2] = mac_sum[47:32];
                    next_state = cce_pkg::ST_IDLE;
                end
                else
                begin
                    next_cnt = cnt + 9'h001;
                    next_state = cce_pkg::ST_COR_X;
                end
            end
        endcase

        // Set wins over acknowledge so no request is lost
        next_irq_pend = irq_request_in | (irq_pend & ~irq_ack_in);
        next_busy = next_state != cce_pkg::ST_IDLE;
        next_irq_srv = next_irq_pend & ~next_busy;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= cce_pkg::ST_IDLE;
            op <= '0;
            flags <= cce_pkg::FLAGS_RST;
            repeat_prefix <= '0;
            pinc <= 1'b0;
            stra <= '0;
            strb <= '0;
            strn <= '0;
            pc <= cce_pkg::WORD_RST;
            mr <= cce_pkg::WORD_RST;
            xreg <= cce_pkg::WORD_RST;
            idx <= '{default: cce_pkg::WORD_RST};
            acc <= '{default: cce_pkg::WORD_RST};
            cnt <= '0;
            borrow <= 1'b0;
            zacc <= 1'b0;
            mem_pend <= 1'b0;
            irq_pend <= 1'b0;
            irq_service_out <= 1'b0;
            busy_out <= 1'b0;
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
        end
        else
        begin
            state <= next_state;
            op <= next_op;
            flags <= next_flags;
            repeat_prefix <= next_rpt;
            pinc <= next_pinc;
            stra <= next_stra;
            strb <= next_strb;
            strn <= next_strn;
            pc <= next_pc;
            mr <= next_mr;
            xreg <= next_xreg;
            idx <= next_idx;
            acc <= next_acc;
            cnt <= next_cnt;
            borrow <= next_borrow;
            zacc <= next_zacc;
            mem_pend <= next_mem_pend;
            irq_pend <= next_irq_pend;
            irq_service_out <= next_irq_srv;
            busy_out <= next_busy;
            wb_ack_out <= next_ack;
            wb_dat_out <= next_rdata;
        end
    end
endmodule

// ==== hw/cce_mac.sv ====
`timescale 1ns/1ps
module cce_mac #(
    parameter int OP_W  = 16,
    parameter int ACC_W = 48
) (
    input  wire logic             clock_in,
    input  wire logic             rst_in,
    input  wire logic             clear_in,
    input  wire logic             en_in,
    input  wire logic [OP_W-1:0]  a_in,
    input  wire logic [OP_W-1:0]  b_in,
    output logic      [ACC_W-1:0] acc_out,
    output logic      [ACC_W-1:0] sum_out
);
    logic signed [2*OP_W-1:0] product;
    logic        [ACC_W-1:0]  next_acc;

    always_comb
    begin
        product  = $signed(a_in) * $signed(b_in);
        sum_out  = acc_out + ACC_W'(product);
        next_acc = acc_out;
        if (clear_in)
        begin
            next_acc = '0;
        end
        else if (en_in)
        begin
            next_acc = sum_out;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            acc_out <= '0;
        end
        else
        begin
            acc_out <= next_acc;
        end
    end
endmodule

// ==== hw/cce_pkg.sv ====
package cce_pkg;
    // Register byte offsets on the bus (12-bit byte address)
    localparam logic [11:0] OFS_CMD   = 12'h000;
    localparam logic [11:0] OFS_STAT  = 12'h004;
    localparam logic [11:0] OFS_CFG   = 12'h008;
    localparam logic [11:0] OFS_STRA  = 12'h00C;
    localparam logic [11:0] OFS_STRB  = 12'h010;
    localparam logic [11:0] OFS_STRN  = 12'h014;
    localparam logic [11:0] OFS_PC    = 12'h018;
    localparam logic [11:0] OFS_MR    = 12'h01C;
    localparam logic [11:0] OFS_IDX   = 12'h040;
    localparam logic [11:0] OFS_ACC   = 12'h080;
    localparam logic [11:0] OFS_MEM   = 12'h400;

    // Status, command, config and memory-word bit positions
    localparam int FLG_OVF  = 0;
    localparam int FLG_SGN  = 1;
    localparam int FLG_ZER  = 2;
    localparam int FLG_CAR  = 3;
    localparam int FLG_PCAR = 4;
    localparam int FLG_PZER = 5;
    localparam int FLG_TAG  = 6;
    localparam int FLG_BAD  = 7;
    localparam int CMD_BUSY = 17;
    localparam int CFG_PINC = 8;
    localparam int MEM_TAG  = 16;

    // Reset values
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [15:0] WORD_RST  = 16'h0000;

    // Fixed machine sizes and register numbers
    localparam int NUM_REGS   = 8;
    localparam int MEM_ADDR_W = 8;
    localparam int MEM_DATA_W = 17;
    localparam logic [2:0] STEP_REG = 3'h5;
    localparam logic [2:0] ALT_OFS  = 3'h4;

    // Opcode patterns
    localparam logic [6:0] OP_BYTE_ACC = 7'h53;
    localparam logic [5:0] OP_BYTE_IDX = 6'h2F;
    localparam logic [6:0] OP_STR_MEM  = 7'h2D;
    localparam logic [6:0] OP_STR_REG  = 7'h73;
    localparam logic [5:0] OP_STR_PMA  = 6'h19;
    localparam logic [5:0] OP_STR_ACC  = 6'h20;
    localparam logic [6:0] OP_COR      = 7'h74;
    localparam logic [2:0] OP_COR_MID  = 3'h6;
    localparam logic [1:0] OP_COR_LOW  = 2'h3;

    typedef enum {
        ST_IDLE,
        ST_STR_RD,
        ST_STR_CMP,
        ST_COR_X,
        ST_COR_H,
        ST_COR_MAC
    } cce_state_e;
endpackage

// ==== hw/cce_word_mem.sv ====
`timescale 1ns/1ps
module cce_word_mem #(
    parameter int DATA_W = 17,
    parameter int ADDR_W = 8
) (
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire logic              we_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    output logic      [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] mem [2**ADDR_W];

    always_ff @(posedge clock_in)
    begin
        if (we_in)
        begin
            mem[addr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_out <= '0;
        end
        else
        begin
            rdata_out <= mem[addr_in];
        end
    end
endmodule

// ==== test/cce_exec_monitor.sv ====
`timescale 1ns/1ps
module cce_exec_monitor (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [11:0] wb_adr_in,
    input wire logic [3:0]  wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    input wire logic        irq_request_in,
    input wire logic        irq_ack_in,
    input wire logic        irq_service_out,
    input wire logic        busy_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence cmd_s(logic [6:0] op);
        wb_ack_out && wb_we_in && wb_adr_in == cce_pkg::OFS_CMD
            && wb_sel_in[2:0] == 3'h7 && wb_dat_in[16:10] == op;
    endsequence
    sequence idle_req_s;
        irq_request_in && !busy_out ##1 (!busy_out && !irq_ack_in)[*3];
    endsequence
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack too long");
    ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("stray read data");
    byte_quick_a: assert property (
        cmd_s(cce_pkg::OP_BYTE_ACC) |=> !busy_out[*2])
        else $error("byte busy");
    cor_span_a: assert property (
        cmd_s(cce_pkg::OP_COR) |-> busy_out[*6])
        else $error("correlation too short");
    busy_min_a: assert property ($rose(busy_out) |-> busy_out[*2])
        else $error("busy too short");
    svc_mask_a: assert property (busy_out |-> !irq_service_out)
        else $error("served while busy");
    irq_serve_a: assert property (idle_req_s |-> irq_service_out)
        else $error("irq not served");
endmodule
bind cce_exec cce_exec_monitor mon_u (.clock_in(clock_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .irq_request_in(irq_request_in), .irq_ack_in(irq_ack_in),
    .irq_service_out(irq_service_out), .busy_out(busy_out));

// ==== test/cce_seq_model.sv ====
`timescale 1ns/1ps
module cce_seq_model (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        go_in,
    input  wire logic        ack_in,
    input  wire logic [31:0] rdat_in,
    output logic             cyc_out,
    output logic             done_out,
    output logic [31:0]      rdat_out
);
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cyc_out  <= 1'b0;
            done_out <= 1'b0;
            rdat_out <= 32'h0;
        end
        else if (cyc_out && ack_in)
        begin
            cyc_out  <= 1'b0;
            done_out <= 1'b1;
            rdat_out <= rdat_in;
        end
        else
        begin
            cyc_out  <= cyc_out || (go_in && !done_out);
            done_out <= 1'b0;
        end
    end
endmodule

// ==== test/tb_cce_exec.sv ====
`timescale 1ns/1ps
module tb_cce_exec;
    logic        clock_in, rst_in, go, we, done, cyc, ack;
    logic        irq_req, irq_ack, svc, busy;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat, rdat, s_dat;
    int          n_errors, check_count, cycles, busy_n;
    cce_seq_model seq_u (.clock_in(clock_in), .rst_in(rst_in), .go_in(go),
        .ack_in(ack), .rdat_in(s_dat), .cyc_out(cyc), .done_out(done),
        .rdat_out(rdat));
    cce_exec dut_u (.clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(cyc),
        .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(dat), .wb_dat_out(s_dat), .wb_ack_out(ack),
        .irq_request_in(irq_req), .irq_ack_in(irq_ack),
        .irq_service_out(svc), .busy_out(busy));
    initial
    begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        busy_n <= busy_n + busy;
        if (cycles == 3000)
        begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clock_in);
        go <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do
            @(negedge clock_in);
        while (done !== 1'b1);
        @(posedge clock_in);
        go <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(rdat, e);
    endtask
    task automatic run(input logic [16:0] op, input int exp);
        int n = busy_n;
        wr(cce_pkg::OFS_CMD, {15'h0, op});
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clock_in);
            if (i == 20)
                chk(svc, 1'b1);
            @(posedge clock_in);
            irq_ack <= (i == 0 || i == 22);
            irq_req <= (i == 1 || i == 30);
        end
        chk(busy_n - n, exp);
    endtask
    task automatic t_byte();
        wr(cce_pkg::OFS_STAT, 32'h0);
        wr(cce_pkg::OFS_ACC, 32'h10);
        wr(cce_pkg::OFS_PC, 32'h7);
        wr(cce_pkg::OFS_CMD, {15'h0, cce_pkg::OP_BYTE_ACC, 2'h0, 8'h20});
        rd(cce_pkg::OFS_STAT, 32'hA);
        rd(cce_pkg::OFS_ACC, 32'h10);
        rd(cce_pkg::OFS_PC, 32'h8);
        wr(cce_pkg::OFS_ACC, 32'hF3);
        wr(cce_pkg::OFS_CMD, {15'h0, cce_pkg::OP_BYTE_ACC, 2'h0, 8'hF3});
        rd(cce_pkg::OFS_STAT, 32'h4);
    endtask
    task automatic t_idx();
        wr(cce_pkg::OFS_IDX + 12'hC, 32'h9C);
        wr(cce_pkg::OFS_CMD, {15'h0, cce_pkg::OP_BYTE_IDX, 11'h78C});
        rd(cce_pkg::OFS_STAT, 32'h24);
    endtask
    task automatic t_str();
        wr(cce_pkg::OFS_STAT, 32'h0);
        wr(cce_pkg::OFS_ACC, 32'h0);
        wr(cce_pkg::OFS_ACC + 12'h4, 32'h1);
        wr(cce_pkg::OFS_MEM + 12'h40, 32'h1);
        wr(cce_pkg::OFS_MEM + 12'h44, 32'h10000);
        wr(cce_pkg::OFS_STRB, 32'h10);
        wr(cce_pkg::OFS_STRN, 32'h1);
        run({cce_pkg::OP_STR_MEM, 10'h0}, 4);
        rd(cce_pkg::OFS_STAT, 32'h40);
        rd(cce_pkg::OFS_ACC + 12'h4, 32'h1);
    endtask
    task automatic t_cor();
        logic [7:0]  ma [8] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
                                8'h30, 8'h31, 8'h32};
        logic [15:0] md [8] = '{16'hFFFF, 16'h0100, 16'h0002, 16'h0100,
                                16'h0003, 16'h8000, 16'h0005, 16'h0007};
        for (int i = 0; i < 8; i++)
            wr(cce_pkg::OFS_MEM + {2'h0, ma[i], 2'h0}, {16'h0, md[i]});
        wr(cce_pkg::OFS_STAT, 32'h40);
        wr(cce_pkg::OFS_CFG, 32'h101);
        wr(cce_pkg::OFS_IDX, 32'h20);
        wr(cce_pkg::OFS_IDX + 12'h4, 32'h30);
        wr(cce_pkg::OFS_IDX + 12'h14, 32'h2);
        run({cce_pkg::OP_COR, 2'h1, cce_pkg::OP_COR_MID, 3'h0,
             cce_pkg::OP_COR_LOW}, 9);
        rd(cce_pkg::OFS_ACC + 12'h4, 32'h801F);
        rd(cce_pkg::OFS_ACC + 12'h8, 32'h0);
        rd(cce_pkg::OFS_ACC + 12'hC, 32'h0);
        rd(cce_pkg::OFS_MR, 32'h8000);
    endtask
    task automatic t_misc();
        wr(12'h300, 32'hFFFF);
        rd(12'h300, 32'h0);
        wr(cce_pkg::OFS_MR, 32'h1234);
        rd(cce_pkg::OFS_MR, 32'h8000);
        wr(cce_pkg::OFS_PC, 32'h7);
        bus(1'b1, cce_pkg::OFS_CMD, {15'h0, cce_pkg::OP_BYTE_ACC, 10'h0}, 4'h3);
        rd(cce_pkg::OFS_PC, 32'h7);
    endtask
    initial
    begin
        rst_in = 1'b1;
        {go, we, irq_req, irq_ack} = 4'h0;
        sel = 4'h0;
        adr = 12'h0;
        dat = 32'h0;
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        t_byte();
        t_idx();
        t_str();
        t_cor();
        t_misc();
        results();
    end
endmodule
